// file: tapc_pkg.sv
/*
 * Package for the test access port controller: controller states,
 * instruction codes, register widths and the packed state records of
 * the test-clock and system-clock logic.
 * Assumes the test clock comes from an external boundary-scan tester.
 */
`default_nettype none

package tapc_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int IR_LEN = 4;
    localparam int BSR_LEN = 64;
    localparam int ID_LEN = 32;

    // ==========================================================
    // Instruction codes and capture pattern
    // ==========================================================
    localparam logic [IR_LEN-1:0] INSTR_EXTEST = 4'h0;
    localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 4'h1;
    localparam logic [IR_LEN-1:0] INSTR_IDCODE = 4'h2;
    localparam logic [IR_LEN-1:0] INSTR_BYPASS = 4'hF;
    // Two least significant bits are 01 for serial path checks
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

    // Arbitrary neutral identification value
    localparam logic [ID_LEN-1:0] IDCODE_DEFAULT = 32'h00000001;

    // ==========================================================
    // Controller states
    // ==========================================================
    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } tapc_state_type;

    // ==========================================================
    // State records
    // ==========================================================
    // Rising test-clock edge logic
    typedef struct packed {
        logic rst_meta;
        logic rst_sync_b;
        logic [BSR_LEN-1:0] pin_meta;
        logic [BSR_LEN-1:0] pin_sync;
        tapc_state_type state;
        logic [IR_LEN-1:0] ir_shift;
        logic bypass_shift;
        logic [ID_LEN-1:0] id_shift;
        logic [BSR_LEN-1:0] bsr_shift;
    } tapc_rise_type;

    // Falling test-clock edge logic
    typedef struct packed {
        logic [IR_LEN-1:0] ir_cur;
        logic extest;
        logic [BSR_LEN-1:0] bsr_par;
        logic tdo;
        logic tdo_oe_n;
    } tapc_fall_type;

    // System clock logic
    typedef struct packed {
        logic ext_meta;
        logic ext_sync;
    } tapc_sys_type;

endpackage : tapc_pkg

`default_nettype wire

// file: tapc_top.sv
/*
 * Test access port controller: sixteen-state controller, instruction
 * register, bypass, identification and boundary scan registers.
 * Assumes tck_i comes from the tester and may stop between scans;
 * tms_i and tdi_i are launched by the tester relative to tck_i.
 * The system clock only sees the test-mode level through a
 * two-flop synchroniser.
 */
`timescale 1ns/100ps
`default_nettype none

module tapc_top #(
    parameter logic [tapc_pkg::ID_LEN-1:0] IDCODE_VALUE =
        tapc_pkg::IDCODE_DEFAULT
) (
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Test port from the tester
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    // Boundary pins
    input wire logic [tapc_pkg::BSR_LEN-1:0] bs_pin_i,
    output logic [tapc_pkg::BSR_LEN-1:0] bs_par_o,
    output logic bs_extest_o,
    // Status
    output tapc_pkg::tapc_state_type tap_state_o,
    output logic [tapc_pkg::IR_LEN-1:0] instr_o,
    output logic extest_sys_o
);

    // ==========================================================
    // Controller transition decode
    // ==========================================================
    function automatic tapc_pkg::tapc_state_type tap_next(
        input tapc_pkg::tapc_state_type st,
        input logic tms
    );
        tapc_pkg::tapc_state_type nx;
        nx = tapc_pkg::ST_RESET;
        case (st)
            tapc_pkg::ST_RESET: begin
                // Stays while TMS high; any path reaches here in five
                nx = tms ? tapc_pkg::ST_RESET : tapc_pkg::ST_IDLE;
            end
            tapc_pkg::ST_IDLE: begin
                nx = tms ? tapc_pkg::ST_SEL_DR : tapc_pkg::ST_IDLE;
            end
            tapc_pkg::ST_SEL_DR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_SEL_IR;
                end else begin
                    nx = tapc_pkg::ST_CAP_DR;
                end
            end
            tapc_pkg::ST_CAP_DR: begin
                nx = tms ? tapc_pkg::ST_EXIT1_DR : tapc_pkg::ST_SHIFT_DR;
            end
            tapc_pkg::ST_SHIFT_DR: begin
                nx = tms ? tapc_pkg::ST_EXIT1_DR : tapc_pkg::ST_SHIFT_DR;
            end
            tapc_pkg::ST_EXIT1_DR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_UPD_DR;
                end else begin
                    nx = tapc_pkg::ST_PAUSE_DR;
                end
            end
            tapc_pkg::ST_PAUSE_DR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_EXIT2_DR;
                end else begin
                    nx = tapc_pkg::ST_PAUSE_DR;
                end
            end
            tapc_pkg::ST_EXIT2_DR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_UPD_DR;
                end else begin
                    nx = tapc_pkg::ST_SHIFT_DR;
                end
            end
            tapc_pkg::ST_UPD_DR, tapc_pkg::ST_UPD_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_SEL_DR;
                end else begin
                    nx = tapc_pkg::ST_IDLE;
                end
            end
            tapc_pkg::ST_SEL_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_RESET;
                end else begin
                    nx = tapc_pkg::ST_CAP_IR;
                end
            end
            tapc_pkg::ST_CAP_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_EXIT1_IR;
                end else begin
                    nx = tapc_pkg::ST_SHIFT_IR;
                end
            end
            tapc_pkg::ST_SHIFT_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_EXIT1_IR;
                end else begin
                    nx = tapc_pkg::ST_SHIFT_IR;
                end
            end
            tapc_pkg::ST_EXIT1_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_UPD_IR;
                end else begin
                    nx = tapc_pkg::ST_PAUSE_IR;
                end
            end
            tapc_pkg::ST_PAUSE_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_EXIT2_IR;
                end else begin
                    nx = tapc_pkg::ST_PAUSE_IR;
                end
            end
            tapc_pkg::ST_EXIT2_IR: begin
                if (tms) begin
                    nx = tapc_pkg::ST_UPD_IR;
                end else begin
                    nx = tapc_pkg::ST_SHIFT_IR;
                end
            end
            default: begin
                nx = tapc_pkg::ST_RESET;
            end
        endcase
        return nx;
    endfunction : tap_next

    // Boundary register is the selected path for these two
    function automatic logic uses_bsr(input logic [tapc_pkg::IR_LEN-1:0] ir);
        return (ir == tapc_pkg::INSTR_EXTEST) ||
               (ir == tapc_pkg::INSTR_SAMPLE);
    endfunction : uses_bsr

    function automatic logic uses_id(input logic [tapc_pkg::IR_LEN-1:0] ir);
        return ir == tapc_pkg::INSTR_IDCODE;
    endfunction : uses_id

    // Serial bit of the data path that the instruction selects;
    // unknown codes fall back to bypass
    function automatic logic dr_out(
        input logic [tapc_pkg::IR_LEN-1:0] ir,
        input logic bsr_bit,
        input logic id_bit,
        input logic byp_bit
    );
        logic sel;
        sel = byp_bit;
        if (uses_bsr(ir)) begin
            sel = bsr_bit;
        end else if (uses_id(ir)) begin
            sel = id_bit;
        end
        return sel;
    endfunction : dr_out

    tapc_pkg::tapc_rise_type rise_reg;
    tapc_pkg::tapc_rise_type rise_next;
    tapc_pkg::tapc_fall_type fall_reg;
    tapc_pkg::tapc_fall_type fall_next;
    tapc_pkg::tapc_sys_type sys_reg;
    tapc_pkg::tapc_sys_type sys_next;

    // ==========================================================
    // Rising test-clock edge: controller and shift paths
    // ==========================================================
    // System reset reaches the test clock through two flops; the
    // tester must run tck_i for two rising edges before the falling-edge
    // outputs reset, and for three before the controller state does.
    always_comb begin
        rise_next = rise_reg;
        rise_next.rst_meta = rst_b_i;
        rise_next.rst_sync_b = rise_reg.rst_meta;
        rise_next.pin_meta = bs_pin_i;
        rise_next.pin_sync = rise_reg.pin_meta;
        if (!rise_reg.rst_sync_b) begin
            rise_next.state = tapc_pkg::ST_RESET;
            rise_next.ir_shift = '0;
            rise_next.bypass_shift = 1'b0;
            rise_next.id_shift = '0;
            rise_next.bsr_shift = '0;
        end else begin
            rise_next.state = tap_next(rise_reg.state, tms_i);
            // Pause, exit, select and update states leave shift stages
            // untouched because only the cases below write them
            case (rise_reg.state)
                tapc_pkg::ST_CAP_DR: begin
                    rise_next.bypass_shift = 1'b0;
                    rise_next.id_shift = IDCODE_VALUE;
                    if (uses_bsr(fall_reg.ir_cur)) begin
                        rise_next.bsr_shift = rise_reg.pin_sync;
                    end
                end
                tapc_pkg::ST_SHIFT_DR: begin
                    if (uses_bsr(fall_reg.ir_cur)) begin
                        rise_next.bsr_shift = {tdi_i,
                            rise_reg.bsr_shift[tapc_pkg::BSR_LEN-1:1]};
                    end else if (uses_id(fall_reg.ir_cur)) begin
                        rise_next.id_shift = {tdi_i,
                            rise_reg.id_shift[tapc_pkg::ID_LEN-1:1]};
                    end else begin
                        rise_next.bypass_shift = tdi_i;
                    end
                end
                tapc_pkg::ST_CAP_IR: begin
                    rise_next.ir_shift = tapc_pkg::IR_CAPTURE;
                end
                tapc_pkg::ST_SHIFT_IR: begin
                    rise_next.ir_shift = {tdi_i,
                        rise_reg.ir_shift[tapc_pkg::IR_LEN-1:1]};
                end
                tapc_pkg::ST_PAUSE_DR, tapc_pkg::ST_PAUSE_IR: begin
                    // Tester may stall here as long as it likes
                    rise_next.ir_shift = rise_reg.ir_shift;
                    rise_next.bsr_shift = rise_reg.bsr_shift;
                    rise_next.id_shift = rise_reg.id_shift;
                    rise_next.bypass_shift = rise_reg.bypass_shift;
                end
                tapc_pkg::ST_EXIT1_DR, tapc_pkg::ST_EXIT2_DR,
                tapc_pkg::ST_EXIT1_IR, tapc_pkg::ST_EXIT2_IR,
                tapc_pkg::ST_SEL_DR, tapc_pkg::ST_SEL_IR,
                tapc_pkg::ST_UPD_DR, tapc_pkg::ST_UPD_IR: begin
                    rise_next.ir_shift = rise_reg.ir_shift;
                    rise_next.bsr_shift = rise_reg.bsr_shift;
                    rise_next.id_shift = rise_reg.id_shift;
                    rise_next.bypass_shift = rise_reg.bypass_shift;
                end
                default: begin
                    // Reset and idle states hold every stage
                    rise_next.ir_shift = rise_reg.ir_shift;
                end
            endcase
        end
    end

    always_ff @(posedge tck_i) begin
        rise_reg <= rise_next;
    end

    // ==========================================================
    // Falling test-clock edge: updates and serial output
    // ==========================================================
    // Updating on the falling edge gives the tester half a period
    // of settled shift data before the parallel outputs move.
    always_comb begin
        fall_next = fall_reg;
        fall_next.tdo_oe_n = 1'b1;
        if (!rise_reg.rst_sync_b ||
            rise_reg.state == tapc_pkg::ST_RESET) begin
            fall_next.ir_cur = tapc_pkg::INSTR_IDCODE;
            fall_next.extest = 1'b0;
            fall_next.tdo = 1'b0;
            if (!rise_reg.rst_sync_b) begin
                fall_next.bsr_par = '0;
            end
        end else begin
            case (rise_reg.state)
                tapc_pkg::ST_UPD_IR: begin
                    fall_next.ir_cur = rise_reg.ir_shift;
                    fall_next.extest =
                        (rise_reg.ir_shift == tapc_pkg::INSTR_EXTEST);
                end
                tapc_pkg::ST_UPD_DR: begin
                    if (uses_bsr(fall_reg.ir_cur)) begin
                        fall_next.bsr_par = rise_reg.bsr_shift;
                    end
                end
                tapc_pkg::ST_SHIFT_IR: begin
                    fall_next.tdo = rise_reg.ir_shift[0];
                    fall_next.tdo_oe_n = 1'b0;
                end
                tapc_pkg::ST_SHIFT_DR: begin
                    fall_next.tdo_oe_n = 1'b0;
                    fall_next.tdo = dr_out(fall_reg.ir_cur,
                        rise_reg.bsr_shift[0], rise_reg.id_shift[0],
                        rise_reg.bypass_shift);
                end
                default: begin
                    // Instruction and parallel outputs hold here
                    fall_next.ir_cur = fall_reg.ir_cur;
                end
            endcase
        end
    end

    always_ff @(negedge tck_i) begin
        fall_reg <= fall_next;
    end

    // ==========================================================
    // System clock: test-mode level crossing
    // ==========================================================
    always_comb begin
        sys_next = sys_reg;
        if (!rst_b_i) begin
            sys_next.ext_meta = 1'b0;
            sys_next.ext_sync = 1'b0;
        end else begin
            sys_next.ext_meta = fall_reg.extest;
            sys_next.ext_sync = sys_reg.ext_meta;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        sys_reg <= sys_next;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign tdo_o = fall_reg.tdo;
    assign tdo_oe_n_o = fall_reg.tdo_oe_n;
    assign bs_par_o = fall_reg.bsr_par;
    assign bs_extest_o = fall_reg.extest;
    assign tap_state_o = rise_reg.state;
    assign instr_o = fall_reg.ir_cur;
    assign extest_sys_o = sys_reg.ext_sync;

endmodule : tapc_top

`default_nettype wire

// file: tapc_top_chk.sv
/* Checker of the controller state walk and update timing.
   Assumes it is bound to tapc_top and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module tapc_top_chk (
    // Reset and test port
    input wire logic rst_b_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdo_oe_n_o,
    input wire logic tdo_o,
    // Controller outputs
    input wire tapc_pkg::tapc_state_type tap_state_o,
    input wire logic [3:0] instr_o,
    input wire logic [63:0] bs_par_o,
    input wire logic bs_extest_o
);
    // ==========================================================
    // State walk on rising test clock
    // ==========================================================
    property p_step(s, hi, lo);
        @(posedge tck_i) disable iff (!rst_b_i)
        tap_state_o == s |=> tap_state_o == ($past(tms_i) ? hi : lo);
    endproperty
    sequence s_hold_high;
        tms_i [*5];
    endsequence
    sequence s_cap_shift;
        $past(tap_state_o) == tapc_pkg::ST_CAP_IR &&
            tap_state_o == tapc_pkg::ST_SHIFT_IR;
    endsequence
    a_pause_dr: assert property (p_step(tapc_pkg::ST_PAUSE_DR,
        tapc_pkg::ST_EXIT2_DR, tapc_pkg::ST_PAUSE_DR)) else $error("pause dr");
    a_pause_ir: assert property (p_step(tapc_pkg::ST_PAUSE_IR,
        tapc_pkg::ST_EXIT2_IR, tapc_pkg::ST_PAUSE_IR)) else $error("pause ir");
    a_sel_dr: assert property (p_step(tapc_pkg::ST_SEL_DR,
        tapc_pkg::ST_SEL_IR, tapc_pkg::ST_CAP_DR)) else $error("select dr");
    a_shift_ir: assert property (p_step(tapc_pkg::ST_SHIFT_IR,
        tapc_pkg::ST_EXIT1_IR, tapc_pkg::ST_SHIFT_IR)) else $error("shift ir");
    a_upd_dr: assert property (p_step(tapc_pkg::ST_UPD_DR,
        tapc_pkg::ST_SEL_DR, tapc_pkg::ST_IDLE)) else $error("update dr");
    a_upd_ir: assert property (p_step(tapc_pkg::ST_UPD_IR,
        tapc_pkg::ST_SEL_DR, tapc_pkg::ST_IDLE)) else $error("update ir");
    a_exit1_dr: assert property (p_step(tapc_pkg::ST_EXIT1_DR,
        tapc_pkg::ST_UPD_DR, tapc_pkg::ST_PAUSE_DR)) else $error("exit1 dr");
    a_exit2_dr: assert property (p_step(tapc_pkg::ST_EXIT2_DR,
        tapc_pkg::ST_UPD_DR, tapc_pkg::ST_SHIFT_DR)) else $error("exit2 dr");
    a_sel_ir: assert property (p_step(tapc_pkg::ST_SEL_IR,
        tapc_pkg::ST_RESET, tapc_pkg::ST_CAP_IR)) else $error("select ir");
    a_cap_ir: assert property (p_step(tapc_pkg::ST_CAP_IR,
        tapc_pkg::ST_EXIT1_IR, tapc_pkg::ST_SHIFT_IR)) else $error("cap ir");
    a_exit1_ir: assert property (p_step(tapc_pkg::ST_EXIT1_IR,
        tapc_pkg::ST_UPD_IR, tapc_pkg::ST_PAUSE_IR)) else $error("exit1 ir");
    a_exit2_ir: assert property (p_step(tapc_pkg::ST_EXIT2_IR,
        tapc_pkg::ST_UPD_IR, tapc_pkg::ST_SHIFT_IR)) else $error("exit2 ir");
    a_five_high: assert property (@(posedge tck_i)
        disable iff (!rst_b_i)
        s_hold_high |=> tap_state_o == tapc_pkg::ST_RESET)
        else $error("no reset after five high");
    // ==========================================================
    // Falling edge updates
    // ==========================================================
    a_instr_only_upd: assert property (@(negedge tck_i)
        disable iff (!rst_b_i) !$stable(instr_o) |->
        $past(tap_state_o) inside {tapc_pkg::ST_UPD_IR, tapc_pkg::ST_RESET})
        else $error("instruction moved outside update");
    a_par_only_upd: assert property (@(negedge tck_i)
        disable iff (!rst_b_i) !$stable(bs_par_o) |->
        $past(tap_state_o) == tapc_pkg::ST_UPD_DR)
        else $error("parallel out moved outside update");
    a_pause_quiet: assert property (@(negedge tck_i)
        disable iff (!rst_b_i)
        tap_state_o inside {tapc_pkg::ST_PAUSE_DR, tapc_pkg::ST_PAUSE_IR}
        |=> tdo_oe_n_o) else $error("output driven in pause");
    a_shift_drive: assert property (@(negedge tck_i)
        disable iff (!rst_b_i)
        tap_state_o inside {tapc_pkg::ST_SHIFT_DR, tapc_pkg::ST_SHIFT_IR}
        |=> !tdo_oe_n_o) else $error("output idle in shift");
    a_cap_pattern: assert property (@(negedge tck_i)
        disable iff (!rst_b_i) s_cap_shift |=> tdo_o)
        else $error("capture pattern bit 0 not one");
    a_reset_idcode: assert property (@(negedge tck_i)
        disable iff (!rst_b_i) tap_state_o == tapc_pkg::ST_RESET |=>
        instr_o == tapc_pkg::INSTR_IDCODE && !bs_extest_o)
        else $error("reset state without identification");
endmodule : tapc_top_chk
bind tapc_top tapc_top_chk chk_u (.rst_b_i(rst_b_i), .tck_i(tck_i),
    .tms_i(tms_i), .tdo_oe_n_o(tdo_oe_n_o), .tdo_o(tdo_o),
    .tap_state_o(tap_state_o),
    .instr_o(instr_o), .bs_par_o(bs_par_o), .bs_extest_o(bs_extest_o));
`default_nettype wire

// file: tapc_tester.sv
/* Boundary-scan tester model: makes the test clock, mode and data in.
   Assumes the bench calls its tasks; the clock stands still between. */
`timescale 1ns/100ps
`default_nettype none
module tapc_tester (
    // Test port
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // ==========================================================
    // One 15 ns test clock period per step
    // ==========================================================
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #6.5;
        tdo = tdo_i;
        tck_o = 1'b1;
        #7.5;
        tck_o = 1'b0;
        // Leave the falling edge updates settled before anyone looks
        #1;
    endtask : step
    task automatic go_reset();
        logic d;
        repeat (5) step(1'b1, 1'b0, d);
    endtask : go_reset
endmodule : tapc_tester
`default_nettype wire

// file: tapc_top_bench.sv
/* Bench for the test port controller: tester model on the test port,
   pins and system clock from here. Assumes the checker is bound. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    err_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); \
    end end
module tapc_top_bench;
    // ==========================================================
    // Signals and instances
    // ==========================================================
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic tck, tms, tdi, tdo, oe_n, ext, ext_sys, bit_o;
    logic [63:0] pins = 64'h0;
    logic [63:0] par, cap;
    logic [3:0] instr;
    tapc_pkg::tapc_state_type state;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    tapc_top dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .tck_i(tck),
        .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(oe_n),
        .bs_pin_i(pins), .bs_par_o(par), .bs_extest_o(ext),
        .tap_state_o(state), .instr_o(instr), .extest_sys_o(ext_sys));
    tapc_tester tst_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    // ==========================================================
    // Test port helpers, mode bits go out least significant first
    // ==========================================================
    task automatic mv(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            tst_u.step(seq[i], 1'b0, bit_o);
        end
    endtask : mv
    task automatic shift(input int n, input logic [31:0] din,
            output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            tst_u.step(i == n - 1, din[i], bit_o);
            dout[i] = bit_o;
        end
    endtask : shift
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_ir(input logic [3:0] code);
        mv(8'h03, 4);
        `CHK({state, oe_n}, {tapc_pkg::ST_SHIFT_IR, 1'b0})
        shift(2, {30'h0, code[1:0]}, cap[31:0]);
        mv(8'h00, 3);
        `CHK({state, oe_n}, {tapc_pkg::ST_PAUSE_IR, 1'b1})
        mv(8'h01, 2);
        `CHK(state, tapc_pkg::ST_SHIFT_IR)
        shift(2, {30'h0, code[3:2]}, cap[63:32]);
        `CHK({cap[33:32], cap[1:0]}, tapc_pkg::IR_CAPTURE)
        mv(8'h01, 2);
        `CHK({state, instr}, {tapc_pkg::ST_IDLE, code})
    endtask : t_ir
    // Split scan: pause, resume, pause again, then update from exit 2
    task automatic t_dr(input logic [63:0] pat, input logic [63:0] ep,
            input logic [63:0] ec);
        logic [63:0] p0;
        p0 = par;
        mv(8'h01, 3);
        shift(32, pat[31:0], cap[31:0]);
        mv(8'h00, 1);
        `CHK({state, par}, {tapc_pkg::ST_PAUSE_DR, p0})
        mv(8'h01, 2);
        `CHK(state, tapc_pkg::ST_SHIFT_DR)
        shift(32, pat[63:32], cap[63:32]);
        mv(8'h06, 4);
        `CHK(cap, ec)
        `CHK({state, par}, {tapc_pkg::ST_IDLE, ep})
    endtask : t_dr
    // Identification scan, then an update that leaves boundary outputs
    task automatic t_id();
        logic [31:0] d;
        logic [63:0] p0;
        p0 = par;
        mv(8'h01, 3);
        shift(32, 32'h0, d);
        `CHK(d, tapc_pkg::IDCODE_DEFAULT)
        mv(8'h01, 2);
        `CHK({state, par}, {tapc_pkg::ST_IDLE, p0})
    endtask : t_id
    task automatic t_cap_exit();
        mv(8'h3B, 6);
        `CHK(instr, tapc_pkg::IR_CAPTURE)
        `CHK(state, tapc_pkg::ST_SEL_DR)
        mv(8'h03, 2);
        `CHK({state, instr}, {tapc_pkg::ST_RESET, tapc_pkg::INSTR_IDCODE})
    endtask : t_cap_exit
    task automatic t_reset();
        `CHK(state, tapc_pkg::ST_RESET)
        `CHK({instr, ext, oe_n}, {tapc_pkg::INSTR_IDCODE, 2'b01})
    endtask : t_reset
    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Whole run needs well under a thousand system cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        tst_u.go_reset();
        repeat (4) @(negedge sys_clk_i);
        rst_b_i <= 1'b1;
        pins <= 64'h5A3C_96E1_0F87_D24B;
        tst_u.go_reset();
        t_reset();
        `CHK(ext_sys, 1'b0)
        mv(8'h00, 1);
        t_id();
        t_ir(tapc_pkg::INSTR_SAMPLE);
        t_dr(64'h0123_4567_89AB_CDEF, 64'h0123_4567_89AB_CDEF, pins);
        t_ir(tapc_pkg::INSTR_EXTEST);
        repeat (4) @(negedge sys_clk_i);
        `CHK({ext, ext_sys}, 2'b11)
        t_dr(64'hF0E1_D2C3_B4A5_9687, 64'hF0E1_D2C3_B4A5_9687, pins);
        t_ir(tapc_pkg::INSTR_BYPASS);
        t_dr(64'h8000_0000_0000_0003, 64'hF0E1_D2C3_B4A5_9687, 64'h6);
        t_cap_exit();
        mv(8'h00, 1);
        t_ir(tapc_pkg::INSTR_EXTEST);
        mv(8'h03, 4);
        tst_u.go_reset();
        t_reset();
        wrap_up();
    end
endmodule : tapc_top_bench
`default_nettype wire
